// ### hw/gpio_pkg.sv
// Contract
// [RULE_01] Three ports: ports zero and one have eight bits, port two five.
// [RULE_02] Port data is reachable as a whole byte and as single bits.
// [RULE_03] Function select picks GPIO or peripheral; reset leaves all GPIO.
// [RULE_04] Audio serial enable hands its pins to that interface regardless.
// [RULE_05] Pins reset to input; direction bit one makes an output, anytime; the code ignores it on peripheral-owned pins and drops its writes while asleep.
// [RULE_06] Reading port data returns sampled pin levels, any configuration.
// [RULE_07] Single-bit read-modify-write works on the output latch, not pins.
// [RULE_08] Inputs default to pull-up; input mode bit one tri-states them.
// [RULE_09] Port one pins zero and one have no pull at all.
// [RULE_10] In power modes one to three pins keep mode, direction and output; the code still takes audio enable writes, so audio pins can change hands.
// [RULE_11] GPIO inputs raise interrupt events on a chosen rising or falling edge.
// [RULE_12] Every one of the 21 pins can raise an interrupt.
// [RULE_13] A pin interrupt event can wake the system from any power mode.
// [RULE_14] One port-level CPU enable per port, in enable registers one and two.
// [RULE_15] Port one has one interrupt enable per bit in its own register.
// [RULE_16] Port zero has low and high nibble enables in pin interrupt control.
// [RULE_17] Port two pins share one enable in pin interrupt control.
// [RULE_18] A pin event sets its status flag even with its enable clear.
// [RULE_19] CPU port flag sets only with a pin or nibble enable and an event.
// [RULE_20] Software clears pin status flags before the CPU port flag.
// [RULE_21] Sleep mode field other than zero blocks all port interrupts.
// [RULE_22] Pins pass two sync stages; status flags hold until written zero.
package gpio_pkg;
    localparam int NPINS = 21;
    localparam logic [6:0] OFS_P0_DATA = 7'h00;
    localparam logic [6:0] OFS_P1_DATA = 7'h04;
    localparam logic [6:0] OFS_P2_DATA = 7'h08;
    localparam logic [6:0] OFS_FUNC_SEL = 7'h0C;
    localparam logic [6:0] OFS_DIRECTION = 7'h10;
    localparam logic [6:0] OFS_INPUT_MODE = 7'h14;
    localparam logic [6:0] OFS_P1_PIN_EN = 7'h18;
    localparam logic [6:0] OFS_PIN_IRQ_CTRL = 7'h1C;
    localparam logic [6:0] OFS_P0_FLAGS = 7'h20;
    localparam logic [6:0] OFS_P1_FLAGS = 7'h24;
    localparam logic [6:0] OFS_P2_FLAGS = 7'h28;
    localparam logic [6:0] OFS_CPU_EN_ONE = 7'h2C;
    localparam logic [6:0] OFS_CPU_EN_TWO = 7'h30;
    localparam logic [6:0] OFS_CPU_FLG_ONE = 7'h34;
    localparam logic [6:0] OFS_CPU_FLG_TWO = 7'h38;
    localparam logic [6:0] OFS_SYS_CTRL = 7'h3C;
    localparam logic [6:0] OFS_BIT_ACCESS = 7'h40;
    // Pin interrupt control fields.
    localparam int CTL_EDGE_P0 = 0;
    localparam int CTL_EDGE_P1 = 1;
    localparam int CTL_EDGE_P2 = 2;
    localparam int CTL_P0_LOW_EN = 3;
    localparam int CTL_P0_HIGH_EN = 4;
    localparam int CTL_P2_EN = 5;
    // System control fields: sleep mode in bits 1:0, audio enable in bit 2.
    localparam int SYS_AUDIO_EN = 2;
    // Bit access fields.
    localparam int BA_VALUE = 5;
    localparam int BA_TOGGLE = 6;
    // CPU enable and flag fields.
    localparam int CPU_P1 = 0;
    localparam int CPU_P2 = 1;
    // Pins that carry a pull resistor; port one bits zero and one do not.
    localparam logic [20:0] PULL_CAPABLE = 21'h1FFCFF;
    localparam logic [20:0] RST_PINS = 21'h000000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_CTRL = 6'h00;
    localparam logic [2:0] RST_SMALL = 3'h0;
endpackage : gpio_pkg

// ### hw/gpio_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gpio_sync_if #(parameter int W = 21);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport sync (input raw, output level, rise, fall);
    modport core (output raw, input level, rise, fall);
endinterface : gpio_sync_if
`default_nettype wire

// ### hw/gpio_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_sync #(
    parameter int W = 21
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    gpio_sync_if.sync pins
);
    logic [W-1:0] stage_one;
    logic [W-1:0] stage_two;
    logic [W-1:0] stage_three;
    logic [W-1:0] next_one;
    logic [W-1:0] next_two;
    logic [W-1:0] next_three;

    if (W < 1) begin : g_check
        $error("gpio_pin_sync needs at least one pin");
    end

    always_comb begin
        next_one = pins.raw;
        next_two = stage_one;
        next_three = stage_two;
    end

    // The first stage feeds only the second; edges are taken further on.
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_one <= '0;
            stage_two <= '0;
            stage_three <= '0;
        end else if (ce) begin
            stage_one <= next_one; // RULE_22
            stage_two <= next_two; // RULE_22
            stage_three <= next_three;
        end
    end

    assign pins.level = stage_two;
    assign pins.rise = stage_two & ~stage_three;
    assign pins.fall = ~stage_two & stage_three;
endmodule : gpio_pin_sync
`default_nettype wire

// ### hw/gpio_ports.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_ports
    import gpio_pkg::*;
#(
    // Pins taken over by the audio serial interface when it is enabled.
    parameter logic [20:0] AUDIO_PIN_MASK = 21'h00C003
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [6:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic [20:0] PIN_IN,
    output logic [20:0] PIN_OUT,
    output logic [20:0] PIN_OE,
    output logic [20:0] PIN_PULLUP,
    input wire logic [20:0] PERIPH_OUT,
    input wire logic [20:0] PERIPH_OE,
    output logic IRQ_P0,
    output logic IRQ_P1,
    output logic IRQ_P2,
    output logic WAKE
);
    logic [20:0] latch;
    logic [20:0] sel;
    logic [20:0] dir;
    logic [20:0] inp;
    logic [7:0] p1_en;
    logic [5:0] ctl;
    logic [20:0] flags;
    logic cpu_en_p0;
    logic [1:0] cpu_en_two;
    logic cpu_flg_p0;
    logic [1:0] cpu_flg_two;
    logic [2:0] sys;
    logic [4:0] bit_index;
    logic [20:0] next_latch;
    logic [20:0] next_sel;
    logic [20:0] next_dir;
    logic [20:0] next_inp;
    logic [7:0] next_p1_en;
    logic [5:0] next_ctl;
    logic [20:0] next_flags;
    logic next_cpu_en_p0;
    logic [1:0] next_cpu_en_two;
    logic next_cpu_flg_p0;
    logic [1:0] next_cpu_flg_two;
    logic [2:0] next_sys;
    logic [4:0] next_bit_index;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic [20:0] next_pin_out;
    logic [20:0] next_pin_oe;
    logic [20:0] next_pin_pullup;
    logic next_irq_p0;
    logic next_irq_p1;
    logic next_irq_p2;
    logic next_wake;

    logic [20:0] owned;
    logic [20:0] gpio_in;
    logic [20:0] edge_sel;
    logic [20:0] events;
    logic [20:0] pin_en;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic do_write;
    logic sleeping;
    logic [20:0] ba_mask;

    gpio_sync_if #(.W(NPINS)) pins ();

    gpio_pin_sync #(.W(NPINS)) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .pins(pins)
    );

    assign pins.raw = PIN_IN;

    // Merges byte-lane write data into an old 32-bit view.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    // Flags clear only where software writes a zero in an enabled lane.
    function automatic logic [7:0] clr_zero(input logic [7:0] data,
                                            input logic [7:0] mask);
        clr_zero = ~data & mask;
    endfunction : clr_zero

    // Audio serial interface overrides the function select on its pins.
    assign owned = sel | (AUDIO_PIN_MASK & {NPINS{sys[SYS_AUDIO_EN]}}); // RULE_04
    assign gpio_in = ~owned & ~dir;
    assign edge_sel = {{5{ctl[CTL_EDGE_P2]}}, {8{ctl[CTL_EDGE_P1]}},
                       {8{ctl[CTL_EDGE_P0]}}};
    // Every pin has an event source, selected per port by edge.
    assign events = gpio_in & ((pins.fall & edge_sel) |
                               (pins.rise & ~edge_sel)); // RULE_11 RULE_12
    assign pin_en = {{5{ctl[CTL_P2_EN]}}, p1_en,
                     {4{ctl[CTL_P0_HIGH_EN]}},
                     {4{ctl[CTL_P0_LOW_EN]}}}; // RULE_15 RULE_16 RULE_17
    assign wmask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
                    {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
    assign wval = WRITEDATA & wmask;
    assign do_write = WRITE & ~WAITREQUEST;
    assign sleeping = (sys[1:0] != 2'h0);
    assign ba_mask = (WRITEDATA[4:0] < 5'(NPINS)) ?
                     (21'h000001 << WRITEDATA[4:0]) : RST_PINS;

    // One wait cycle, then a one-cycle answer with registered read data.
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata = READDATA;
        if ((READ | WRITE) && WAITREQUEST) begin
            next_waitrequest = 1'b0;
            next_readdata = 32'h00000000;
            if (ADDRESS == OFS_P0_DATA) begin
                next_readdata = {24'h000000, pins.level[7:0]}; // RULE_06
            end else if (ADDRESS == OFS_P1_DATA) begin
                next_readdata = {24'h000000, pins.level[15:8]}; // RULE_06
            end else if (ADDRESS == OFS_P2_DATA) begin
                next_readdata = {27'h0000000, pins.level[20:16]}; // RULE_01
            end else if (ADDRESS == OFS_FUNC_SEL) begin
                next_readdata = {11'h000, sel};
            end else if (ADDRESS == OFS_DIRECTION) begin
                next_readdata = {11'h000, dir};
            end else if (ADDRESS == OFS_INPUT_MODE) begin
                next_readdata = {11'h000, inp};
            end else if (ADDRESS == OFS_P1_PIN_EN) begin
                next_readdata = {24'h000000, p1_en};
            end else if (ADDRESS == OFS_PIN_IRQ_CTRL) begin
                next_readdata = {26'h0000000, ctl};
            end else if (ADDRESS == OFS_P0_FLAGS) begin
                next_readdata = {24'h000000, flags[7:0]};
            end else if (ADDRESS == OFS_P1_FLAGS) begin
                next_readdata = {24'h000000, flags[15:8]};
            end else if (ADDRESS == OFS_P2_FLAGS) begin
                next_readdata = {27'h0000000, flags[20:16]};
            end else if (ADDRESS == OFS_CPU_EN_ONE) begin
                next_readdata = {31'h00000000, cpu_en_p0};
            end else if (ADDRESS == OFS_CPU_EN_TWO) begin
                next_readdata = {30'h00000000, cpu_en_two};
            end else if (ADDRESS == OFS_CPU_FLG_ONE) begin
                next_readdata = {31'h00000000, cpu_flg_p0};
            end else if (ADDRESS == OFS_CPU_FLG_TWO) begin
                next_readdata = {30'h00000000, cpu_flg_two};
            end else if (ADDRESS == OFS_SYS_CTRL) begin
                next_readdata = {29'h00000000, sys};
            end else if (ADDRESS == OFS_BIT_ACCESS) begin
                next_readdata = {27'h0000000, bit_index};
                // An index past the last pin reads as zero, not unknown.
                next_readdata[BA_VALUE] = (bit_index < 5'(NPINS)) ?
                                          latch[bit_index] : 1'b0; // RULE_07
            end else begin
                next_readdata = 32'h00000000;
            end
        end
    end

    // Configuration, latches and controls written by software.
    always_comb begin
        next_latch = latch;
        next_sel = sel;
        next_dir = dir;
        next_inp = inp;
        next_p1_en = p1_en;
        next_ctl = ctl;
        next_cpu_en_p0 = cpu_en_p0;
        next_cpu_en_two = cpu_en_two;
        next_sys = sys;
        next_bit_index = bit_index;
        // Writes that change pin state are dropped while asleep, except the audio enable
        // in system control, so GPIO pins hold what they had on entry until the sleep field is cleared.
        if (do_write && !sleeping) begin // RULE_10
            if (ADDRESS == OFS_P0_DATA) begin
                next_latch[7:0] = 8'(merge({24'h0, latch[7:0]}, WRITEDATA,
                                           wmask)); // RULE_02
            end else if (ADDRESS == OFS_P1_DATA) begin
                next_latch[15:8] = 8'(merge({24'h0, latch[15:8]}, WRITEDATA,
                                            wmask)); // RULE_02
            end else if (ADDRESS == OFS_P2_DATA) begin
                next_latch[20:16] = 5'(merge({27'h0, latch[20:16]},
                                             WRITEDATA, wmask)); // RULE_01
            end else if (ADDRESS == OFS_FUNC_SEL) begin
                next_sel = 21'(merge({11'h0, sel}, WRITEDATA, wmask));
            end else if (ADDRESS == OFS_DIRECTION) begin
                next_dir = 21'(merge({11'h0, dir}, WRITEDATA,
                                     wmask)); // RULE_05
            end else if (ADDRESS == OFS_INPUT_MODE) begin
                next_inp = 21'(merge({11'h0, inp}, WRITEDATA, wmask));
            end else if (ADDRESS == OFS_BIT_ACCESS && BYTEENABLE[0]) begin
                next_bit_index = WRITEDATA[4:0];
                // The latch bit, not the pin, is read and written back.
                if (WRITEDATA[BA_TOGGLE]) begin
                    next_latch = latch ^ ba_mask; // RULE_07
                end else if (WRITEDATA[BA_VALUE]) begin
                    next_latch = latch | ba_mask; // RULE_02
                end else begin
                    next_latch = latch & ~ba_mask; // RULE_02
                end
            end
        end
        if (do_write) begin
            if (ADDRESS == OFS_P1_PIN_EN && BYTEENABLE[0]) begin
                next_p1_en = WRITEDATA[7:0]; // RULE_15
            end else if (ADDRESS == OFS_PIN_IRQ_CTRL && BYTEENABLE[0]) begin
                next_ctl = WRITEDATA[5:0]; // RULE_16 RULE_17
            end else if (ADDRESS == OFS_CPU_EN_ONE && BYTEENABLE[0]) begin
                next_cpu_en_p0 = WRITEDATA[0]; // RULE_14
            end else if (ADDRESS == OFS_CPU_EN_TWO && BYTEENABLE[0]) begin
                next_cpu_en_two = WRITEDATA[1:0]; // RULE_14
            end else if (ADDRESS == OFS_SYS_CTRL && BYTEENABLE[0]) begin
                next_sys = WRITEDATA[2:0];
            end
        end
    end

    // Status flags and CPU flags; a new event beats a clear in one cycle.
    always_comb begin
        next_flags = flags;
        next_cpu_flg_p0 = cpu_flg_p0;
        next_cpu_flg_two = cpu_flg_two;
        if (do_write) begin
            if (ADDRESS == OFS_P0_FLAGS) begin
                next_flags[7:0] = flags[7:0] & ~clr_zero(wval[7:0],
                                                         wmask[7:0]); // RULE_22
            end else if (ADDRESS == OFS_P1_FLAGS) begin
                next_flags[15:8] = flags[15:8] & ~clr_zero(wval[7:0],
                                                           wmask[7:0]); // RULE_22
            end else if (ADDRESS == OFS_P2_FLAGS) begin
                next_flags[20:16] = flags[20:16] &
                                    ~5'(clr_zero(wval[7:0], wmask[7:0]));
            end else if (ADDRESS == OFS_CPU_FLG_ONE && BYTEENABLE[0]) begin
                next_cpu_flg_p0 = cpu_flg_p0 & WRITEDATA[0];
            end else if (ADDRESS == OFS_CPU_FLG_TWO && BYTEENABLE[0]) begin
                next_cpu_flg_two = cpu_flg_two & WRITEDATA[1:0];
            end
        end
        // Status flags set whether or not the pin is enabled.
        next_flags = next_flags | events; // RULE_18
        // A flagged pin that is enabled keeps the CPU flag raised, so the
        // pin flag must go first or the CPU flag simply comes back.
        if (!sleeping) begin // RULE_21
            if (|(flags[7:0] & pin_en[7:0])) begin
                next_cpu_flg_p0 = 1'b1; // RULE_19 RULE_20
            end
            if (|(flags[15:8] & pin_en[15:8])) begin
                next_cpu_flg_two[CPU_P1] = 1'b1; // RULE_19
            end
            if (|(flags[20:16] & pin_en[20:16])) begin
                next_cpu_flg_two[CPU_P2] = 1'b1; // RULE_19
            end
        end
    end

    // Registered pin drive, pulls, interrupt lines and wake.
    always_comb begin
        next_pin_oe = (owned & PERIPH_OE) | (~owned & dir); // RULE_03 RULE_05
        next_pin_out = (owned & PERIPH_OUT) | (~owned & latch); // RULE_03
        next_pin_pullup = ~owned & ~dir & ~inp & PULL_CAPABLE; // RULE_08 RULE_09
        next_irq_p0 = cpu_flg_p0 & cpu_en_p0 & ~sleeping; // RULE_14 RULE_21
        next_irq_p1 = cpu_flg_two[CPU_P1] & cpu_en_two[CPU_P1] & ~sleeping;
        next_irq_p2 = cpu_flg_two[CPU_P2] & cpu_en_two[CPU_P2] & ~sleeping;
        // Wake runs even while sleeping, since it is what ends the sleep.
        next_wake = |(events & pin_en); // RULE_13
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            latch <= RST_PINS;
            sel <= RST_PINS; // RULE_03
            dir <= RST_PINS; // RULE_05
            inp <= RST_PINS; // RULE_08
            p1_en <= RST_BYTE;
            ctl <= RST_CTRL;
            flags <= RST_PINS;
            cpu_en_p0 <= 1'b0;
            cpu_en_two <= 2'h0;
            cpu_flg_p0 <= 1'b0;
            cpu_flg_two <= 2'h0;
            sys <= RST_SMALL;
            bit_index <= 5'h00;
            READDATA <= 32'h00000000;
            WAITREQUEST <= 1'b1;
            PIN_OUT <= RST_PINS;
            PIN_OE <= RST_PINS;
            PIN_PULLUP <= RST_PINS;
            IRQ_P0 <= 1'b0;
            IRQ_P1 <= 1'b0;
            IRQ_P2 <= 1'b0;
            WAKE <= 1'b0;
        end else if (CE) begin
            latch <= next_latch;
            sel <= next_sel;
            dir <= next_dir;
            inp <= next_inp;
            p1_en <= next_p1_en;
            ctl <= next_ctl;
            flags <= next_flags;
            cpu_en_p0 <= next_cpu_en_p0;
            cpu_en_two <= next_cpu_en_two;
            cpu_flg_p0 <= next_cpu_flg_p0;
            cpu_flg_two <= next_cpu_flg_two;
            sys <= next_sys;
            bit_index <= next_bit_index;
            READDATA <= next_readdata;
            WAITREQUEST <= next_waitrequest;
            PIN_OUT <= next_pin_out;
            PIN_OE <= next_pin_oe;
            PIN_PULLUP <= next_pin_pullup;
            IRQ_P0 <= next_irq_p0;
            IRQ_P1 <= next_irq_p1;
            IRQ_P2 <= next_irq_p2;
            WAKE <= next_wake;
        end
    end
endmodule : gpio_ports
`default_nettype wire

// ### sim/gpio_ports_sva.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_sva
    import gpio_pkg::*;
#(
    parameter logic [20:0] AUDIO_PIN_MASK = 21'h00C003
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [6:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    input wire logic WAITREQUEST,
    input wire logic [20:0] PIN_IN,
    input wire logic [20:0] PIN_OUT,
    input wire logic [20:0] PIN_OE,
    input wire logic [20:0] PIN_PULLUP,
    input wire logic [20:0] PERIPH_OE,
    input wire logic IRQ_P0,
    input wire logic IRQ_P1,
    input wire logic IRQ_P2,
    input wire logic WAKE
);
    // The registers are hidden, so committed bus writes are shadowed here.
    logic [2:0] sys;
    logic [2:0] next_sys;
    logic en0;
    logic next_en0;
    logic wr_ok;
    assign wr_ok = CE && WRITE && !WAITREQUEST && BYTEENABLE[0];
    always_comb begin
        next_sys = sys;
        next_en0 = en0;
        if (wr_ok && ADDRESS == OFS_SYS_CTRL) begin
            next_sys = WRITEDATA[2:0];
        end
        if (wr_ok && ADDRESS == OFS_CPU_EN_ONE) begin
            next_en0 = WRITEDATA[0];
        end
        if (SYS_RST) begin
            next_sys = 3'h0;
            next_en0 = 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        sys <= next_sys;
        en0 <= next_en0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence answer_s;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    sequence asleep_s;
        (sys[1:0] != 2'h0) [*2];
    endsequence
    AST_BUS_ANSWER: assert property (CE && (READ || WRITE) && WAITREQUEST
        |=> answer_s) else $error("bus answer malformed");
    AST_RESET_STATE: assert property ($fell(SYS_RST) |-> PIN_OE == 21'h000000
        ##[0:1] PIN_PULLUP == 21'h1FFCFF) else $error("reset pins");
    AST_NO_PULL: assert property (PIN_PULLUP[9:8] == 2'b00)
        else $error("pull on pin without pull");
    AST_SLEEP_BLOCK: assert property (asleep_s |-> !(IRQ_P0 || IRQ_P1 ||
        IRQ_P2)) else $error("interrupt while asleep");
    AST_RETAIN: assert property (asleep_s |-> $stable(PIN_OE) &&
        $stable(PIN_OUT)) else $error("pins changed asleep");
    AST_AUDIO_OWN: assert property ((sys == 3'b100) [*2] |->
        (PIN_OE & AUDIO_PIN_MASK) == ($past(PERIPH_OE) & AUDIO_PIN_MASK))
        else $error("audio pins not handed over");
    AST_P0_ENABLE: assert property (!en0 [*2] |-> !IRQ_P0)
        else $error("port zero irq without enable");
    AST_WAKE_SYNC: assert property (WAKE |->
        $past(PIN_IN, 2) != $past(PIN_IN, 3) ||
        $past(PIN_IN, 3) != $past(PIN_IN, 4) ||
        $past(PIN_IN, 4) != $past(PIN_IN, 5))
        else $error("wake without pin edge");
endmodule : gpio_ports_sva
bind gpio_ports gpio_ports_sva #(.AUDIO_PIN_MASK(AUDIO_PIN_MASK)) sva_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
    .WAITREQUEST(WAITREQUEST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .PERIPH_OE(PERIPH_OE),
    .IRQ_P0(IRQ_P0), .IRQ_P1(IRQ_P1), .IRQ_P2(IRQ_P2), .WAKE(WAKE)
);
`default_nettype wire

// ### sim/pin_world.sv
`timescale 1ns/10ps
`default_nettype none
module pin_world (
    input wire logic clk,
    input wire logic [20:0] drive_val,
    input wire logic [20:0] drive_oe,
    input wire logic [20:0] pull_en,
    input wire logic [20:0] ext_val,
    input wire logic [20:0] ext_en,
    output logic [20:0] level
);
    // A floating pin flips every cycle, so no test can lean on it.
    logic [20:0] float_pat = 21'h0AAAAA;
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end
    assign level = (drive_oe & drive_val)
        | (~drive_oe & ext_en & ext_val)
        | (~drive_oe & ~ext_en & (pull_en | float_pat));
endmodule : pin_world
`default_nettype wire

// ### sim/gpio_ports_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_tb
    import gpio_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [20:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic [20:0] periph_out = 21'h0;
    logic [20:0] periph_oe = 21'h0;
    logic [20:0] ext_val = 21'h0;
    logic irq_p0, irq_p1, irq_p2;
    int err_total = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    gpio_ports gpio_ports_inst (
        .CLK(clk), .SYS_RST(rst), .CE(1'b1), .ADDRESS(address),
        .READ(read), .WRITE(write), .BYTEENABLE(4'hF),
        .WRITEDATA(writedata), .READDATA(readdata),
        .WAITREQUEST(waitrequest), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN_PULLUP(pin_pullup), .PERIPH_OUT(periph_out),
        .PERIPH_OE(periph_oe), .IRQ_P0(irq_p0), .IRQ_P1(irq_p1),
        .IRQ_P2(irq_p2), .WAKE()
    );
    pin_world pin_world_inst (
        .clk(clk), .drive_val(pin_out), .drive_oe(pin_oe),
        .pull_en(pin_pullup), .ext_val(ext_val), .ext_en(21'h1FFFFF),
        .level(pin_in)
    );
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic xfer(input logic wr, input logic [6:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                err_total++;
                $display("[FAIL] %0t bus answer timed out", $time);
                final_report();
            end
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : rdc
    task automatic pins(input logic [20:0] got, input logic [20:0] exp);
        check({11'h000, got}, {11'h000, exp});
    endtask : pins
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(OFS_FUNC_SEL, 32'h0);
        rdc(OFS_DIRECTION, 32'h0);
        rdc(7'h7C, 32'h0);
        pins(pin_pullup, 21'h1FFCFF);
        ext_val <= 21'h15A5C3;
        repeat (4) @(posedge clk);
        rdc(OFS_P0_DATA, 32'hC3);
        rdc(OFS_P1_DATA, 32'hA5);
        rdc(OFS_P2_DATA, 32'h15);
        wr(OFS_P0_DATA, 32'h3C);
        wr(OFS_DIRECTION, 32'hFF);
        repeat (4) @(posedge clk);
        pins(pin_oe, 21'h0000FF);
        rdc(OFS_P0_DATA, 32'h3C);
        // Pin P1_0 reads high, so a toggle taken from the pin would differ.
        wr(OFS_BIT_ACCESS, 32'h29);
        wr(OFS_BIT_ACCESS, 32'h48);
        rdc(OFS_BIT_ACCESS, 32'h28);
        wr(OFS_BIT_ACCESS, 32'h35);
        wr(OFS_DIRECTION, 32'hFFFF);
        repeat (4) @(posedge clk);
        pins(pin_out & 21'h00FF00, 21'h000300);
        rdc(OFS_P1_DATA, 32'h03);
        wr(OFS_DIRECTION, 32'h0);
        wr(OFS_INPUT_MODE, 32'h1FFFFF);
        repeat (2) @(posedge clk);
        pins(pin_pullup, 21'h000000);
        wr(OFS_INPUT_MODE, 32'h0);
        ext_val <= 21'h000000;
        repeat (6) @(posedge clk);
        wr(OFS_P0_FLAGS, 32'h0);
        wr(OFS_P1_FLAGS, 32'h0);
        wr(OFS_P2_FLAGS, 32'h0);
        wr(OFS_P1_PIN_EN, 32'h04);
        wr(OFS_PIN_IRQ_CTRL, 32'h28);
        wr(OFS_CPU_EN_ONE, 32'h1);
        wr(OFS_CPU_EN_TWO, 32'h3);
        ext_val <= 21'h1FFFFF;
        repeat (8) @(posedge clk);
        rdc(OFS_P0_FLAGS, 32'hFF);
        rdc(OFS_P1_FLAGS, 32'hFF);
        rdc(OFS_P2_FLAGS, 32'h1F);
        rdc(OFS_CPU_FLG_ONE, 32'h1);
        rdc(OFS_CPU_FLG_TWO, 32'h3);
        check({29'h0, irq_p0, irq_p1, irq_p2}, 32'h7);
        wr(OFS_P1_PIN_EN, 32'h0);
        wr(OFS_P1_FLAGS, 32'h0);
        wr(OFS_CPU_FLG_TWO, 32'h0);
        wr(OFS_PIN_IRQ_CTRL, 32'h2A);
        ext_val <= 21'h1F00FF;
        repeat (8) @(posedge clk);
        rdc(OFS_P1_FLAGS, 32'hFF);
        rdc(OFS_CPU_FLG_TWO, 32'h2);
        wr(OFS_P0_DATA, 32'h01);
        wr(OFS_DIRECTION, 32'h1);
        wr(OFS_SYS_CTRL, 32'h1);
        wr(OFS_DIRECTION, 32'h0);
        repeat (2) @(posedge clk);
        pins(pin_oe & pin_out, 21'h000001);
        check({31'h0, irq_p2}, 32'h0);
        wr(OFS_SYS_CTRL, 32'h4);
        wr(OFS_FUNC_SEL, 32'h4);
        periph_oe <= 21'h00C007;
        periph_out <= 21'h000004;
        repeat (2) @(posedge clk);
        pins(pin_oe & 21'h00C007, 21'h00C007);
        pins(pin_out & 21'h00C007, 21'h000004);
        final_report();
    end
endmodule : gpio_ports_tb
`default_nettype wire
